// File: core/wdc_top.sv
// Function
// - Retriggerable one-shot; terminal count resets or interrupts the device.
// - Counter advances only on edges of the dedicated watchdog oscillator.
// - Only on and off; once on it counts until refreshed or timed out.
// - Refresh operation or always-on option bit turns the watchdog on.
// - With always-on option set, counting starts right after reset.
// - Counter is a 24-bit reloadable down counter fed by three bytes.
// - Time-out period is reload value oscillator periods, value over ten ms.
// - Reload is upper byte bits 23:16, middle 15:8, lower 7:0.
// - Refresh is ignored once the count has reached 000002H.
// - Reading a reload byte returns live count byte; write updates that byte.
// - Configurable time-out response: system reset or interrupt.
// - Reset-mode time-out requests system reset in normal and halt modes.
//
// Strobed register access was chosen for this implementation.
`default_nettype none
module wdc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire wdc_pkg::wdc_reg_req_t regReq,
    output logic [7:0] regRdData,
    // Watchdog oscillator and refresh
    input wire logic wdogOscClk,
    input wire logic guardTimerRefreshOp,
    input wire logic alwaysOnOptionBit,
    // Responses and status
    output logic sysResetReq,
    output logic timeoutIrq,
    output logic wdogOn
);

    wdc_pkg::wdc_state_t state_q;
    wdc_pkg::wdc_state_t state_d;
    logic [7:0] reloadUpper_q;
    logic [7:0] reloadMiddle_q;
    logic [7:0] reloadLower_q;
    logic irqMode_q;
    logic started_q;
    logic [wdc_pkg::WDC_SYNC_STAGES-1:0] oscSync_q;
    logic oscPrev_q;
    logic [7:0] regRdData_q;
    logic sysResetReq_q;
    logic timeoutIrq_q;
    logic wdogOn_q;

    logic [23:0] reloadValue;
    logic [23:0] count;
    logic oscTick;
    logic startNow;
    logic refreshAccept;
    logic timeout;
    logic counterLoad;
    logic counterDec;
    logic isOn;
    logic selCtrl;
    logic selUpper;
    logic selMiddle;
    logic selLower;
    logic [7:0] rdMux;

    // The oscillator pin is sampled twice before its edge is looked at.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            oscSync_q <= '0;
            oscPrev_q <= 1'b0;
        end
        else
        begin
            oscSync_q <= {oscSync_q[wdc_pkg::WDC_SYNC_STAGES-2:0], wdogOscClk};
            oscPrev_q <= oscSync_q[wdc_pkg::WDC_SYNC_STAGES-1];
        end
    end

    assign oscTick = oscSync_q[wdc_pkg::WDC_SYNC_STAGES-1] & ~oscPrev_q;

    assign reloadValue = {reloadUpper_q, reloadMiddle_q, reloadLower_q};
    assign isOn = (state_q == wdc_pkg::WDC_ON);
    assign startNow = ~started_q;

    // Once the count is at or below the limit a refresh can no longer save it.
    assign refreshAccept = guardTimerRefreshOp &
        (~isOn | (count > wdc_pkg::WDC_NO_REFRESH_LIMIT));

    // Terminal count: any tick while the counter is at one or at zero.
    assign timeout = isOn & oscTick & (count <= wdc_pkg::WDC_TERMINAL);

    // Interrupt mode retriggers itself; reset mode waits for the system reset.
    assign counterLoad = refreshAccept | startNow | (timeout & irqMode_q);
    assign counterDec = isOn & oscTick & (count != wdc_pkg::WDC_ZERO);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            wdc_pkg::WDC_OFF:
            begin
                if (guardTimerRefreshOp | (startNow & alwaysOnOptionBit))
                begin
                    state_d = wdc_pkg::WDC_ON;
                end
            end
            wdc_pkg::WDC_ON:
            begin
                state_d = wdc_pkg::WDC_ON;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= wdc_pkg::WDC_OFF;
            started_q <= 1'b0;
            wdogOn_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            started_q <= 1'b1;
            wdogOn_q <= (state_d == wdc_pkg::WDC_ON);
        end
    end

    wdc_down_counter #(
        .WIDTH(wdc_pkg::WDC_COUNT_W),
        .RESET_VAL(wdc_pkg::WDC_COUNT_RST)
    ) uCounter (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(counterLoad),
        .loadValue(reloadValue),
        .dec(counterDec),
        .count(count)
    );

    // Response outputs are one-cycle pulses per terminal count.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sysResetReq_q <= 1'b0;
            timeoutIrq_q <= 1'b0;
        end
        else
        begin
            sysResetReq_q <= timeout & ~irqMode_q;
            timeoutIrq_q <= timeout & irqMode_q;
        end
    end

    function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] offset);
        return (addr == offset);
    endfunction

    assign selCtrl = addrHit(regReq.addr, wdc_pkg::WDC_OFF_CTRL);
    assign selUpper = addrHit(regReq.addr, wdc_pkg::WDC_OFF_UPPER);
    assign selMiddle = addrHit(regReq.addr, wdc_pkg::WDC_OFF_MIDDLE);
    assign selLower = addrHit(regReq.addr, wdc_pkg::WDC_OFF_LOWER);

    // Reload bytes read back the live count, not the stored reload.
    assign rdMux = selUpper ? count[23:16] :
        selMiddle ? count[15:8] :
        selLower ? count[7:0] :
        selCtrl ? {6'h00, isOn, irqMode_q} : 8'h00;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reloadUpper_q <= wdc_pkg::WDC_RST_UPPER;
            reloadMiddle_q <= wdc_pkg::WDC_RST_MIDDLE;
            reloadLower_q <= wdc_pkg::WDC_RST_LOWER;
            irqMode_q <= wdc_pkg::WDC_RST_CTRL[wdc_pkg::WDC_CTRL_IRQ_BIT];
        end
        else if (regReq.wr)
        begin
            if (selUpper)
            begin
                reloadUpper_q <= regReq.wrData;
            end
            if (selMiddle)
            begin
                reloadMiddle_q <= regReq.wrData;
            end
            if (selLower)
            begin
                reloadLower_q <= regReq.wrData;
            end
            if (selCtrl)
            begin
                irqMode_q <= regReq.wrData[wdc_pkg::WDC_CTRL_IRQ_BIT];
            end
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            regRdData_q <= 8'h00;
        end
        else
        begin
            regRdData_q <= regReq.rd ? rdMux : 8'h00;
        end
    end

    assign regRdData = regRdData_q;
    assign sysResetReq = sysResetReq_q;
    assign timeoutIrq = timeoutIrq_q;
    assign wdogOn = wdogOn_q;

    AST_REFRESH_RELOADS: assert property (@(posedge clk_sys) disable iff (rst)
        (refreshAccept && !regReq.wr) |=> (count == $past(reloadValue)))
        else $error("accepted refresh did not reload the counter");

    AST_REFRESH_LOCKED: assert property (@(posedge clk_sys) disable iff (rst)
        (isOn && guardTimerRefreshOp && count <= wdc_pkg::WDC_NO_REFRESH_LIMIT
            && !oscTick) |=> (count == $past(count)))
        else $error("refresh taken after the count reached two");

    AST_TICK_DECREMENTS: assert property (@(posedge clk_sys) disable iff (rst)
        (isOn && oscTick && count > wdc_pkg::WDC_TERMINAL && !counterLoad)
            |=> (count == $past(count) - 24'h000001))
        else $error("counter did not step down on an oscillator tick");

    AST_COUNT_ONLY_ON_TICK: assert property (@(posedge clk_sys) disable iff (rst)
        (!oscTick && !counterLoad) |=> $stable(count))
        else $error("counter moved without an oscillator tick");

    AST_RESET_RESPONSE: assert property (@(posedge clk_sys) disable iff (rst)
        (timeout && !irqMode_q) |=> (sysResetReq && !timeoutIrq))
        else $error("reset-mode time-out gave no reset request");

    AST_IRQ_RESPONSE: assert property (@(posedge clk_sys) disable iff (rst)
        (timeout && irqMode_q) |=> (timeoutIrq && !sysResetReq
            && count == $past(reloadValue)))
        else $error("interrupt-mode time-out did not interrupt and retrigger");

    AST_STAYS_ON: assert property (@(posedge clk_sys) disable iff (rst)
        wdogOn |=> wdogOn)
        else $error("watchdog turned off after being enabled");

    AST_ALWAYS_ON: assert property (@(posedge clk_sys) disable iff (rst)
        (startNow && alwaysOnOptionBit) |=> (isOn ##1 wdogOn))
        else $error("always-on option did not start the watchdog");

    AST_REFRESH_ENABLES: assert property (@(posedge clk_sys) disable iff (rst)
        (!isOn && guardTimerRefreshOp) |=> isOn)
        else $error("refresh did not turn the watchdog on");

    AST_READ_LIVE: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.rd && selMiddle) |=> (regRdData == $past(count[15:8])))
        else $error("middle byte read did not return the live count");

    AST_WRITE_ONE_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.wr && selLower) |=> (reloadValue[7:0] == $past(regReq.wrData)
            && reloadValue[23:8] == $past(reloadValue[23:8])))
        else $error("lower byte write touched other reload bits");

    AST_WRITE_UPPER_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.wr && selUpper) |=> (reloadValue[23:16] == $past(regReq.wrData)
            && reloadValue[15:0] == $past(reloadValue[15:0])))
        else $error("upper byte write touched other reload bits");

    AST_WRITE_MIDDLE_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.wr && selMiddle) |=> (reloadValue[15:8] == $past(regReq.wrData)
            && reloadValue[23:16] == $past(reloadValue[23:16])
            && reloadValue[7:0] == $past(reloadValue[7:0])))
        else $error("middle byte write touched other reload bits");

    AST_RELOAD_HOLDS: assert property (@(posedge clk_sys) disable iff (rst)
        !regReq.wr |=> $stable(reloadValue))
        else $error("reload value changed without a write");

    AST_READ_UPPER: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.rd && selUpper) |=> (regRdData == $past(count[23:16])))
        else $error("upper byte read did not return the live count");

    AST_READ_LOWER: assert property (@(posedge clk_sys) disable iff (rst)
        (regReq.rd && selLower) |=> (regRdData == $past(count[7:0])))
        else $error("lower byte read did not return the live count");

    AST_READ_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        !regReq.rd |=> (regRdData == 8'h00))
        else $error("read data present without a read strobe");

    AST_OFF_SILENT: assert property (@(posedge clk_sys) disable iff (rst)
        !isOn |=> (!sysResetReq && !timeoutIrq))
        else $error("time-out response while the watchdog was off");

    AST_RESET_MODE_HOLDS_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        (timeout && !irqMode_q) |=> (count == wdc_pkg::WDC_ZERO))
        else $error("reset-mode time-out did not leave the counter at zero");

    AST_ONE_RESPONSE: assert property (@(posedge clk_sys) disable iff (rst)
        !(sysResetReq && timeoutIrq))
        else $error("reset and interrupt responses raised together");

    AST_OSC_TICK_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(wdogOscClk) |-> ##2 oscTick)
        else $error("oscillator edge did not become a tick two cycles later");

endmodule
`default_nettype wire

// File: core/wdc_pkg.sv
`default_nettype none
package wdc_pkg;

    // Register addresses on the plain register port.
    localparam int unsigned WDC_ADDR_W = 12;
    localparam int unsigned WDC_DATA_W = 8;
    localparam logic [11:0] WDC_OFF_CTRL = 12'hFF0;
    localparam logic [11:0] WDC_OFF_UPPER = 12'hFF1;
    localparam logic [11:0] WDC_OFF_MIDDLE = 12'hFF2;
    localparam logic [11:0] WDC_OFF_LOWER = 12'hFF3;

    // Reset values of the reload bytes and the control register.
    localparam logic [7:0] WDC_RST_UPPER = 8'h00;
    localparam logic [7:0] WDC_RST_MIDDLE = 8'h04;
    localparam logic [7:0] WDC_RST_LOWER = 8'h00;
    localparam logic [7:0] WDC_RST_CTRL = 8'h00;

    // Control register fields.
    localparam int unsigned WDC_CTRL_IRQ_BIT = 0;
    localparam int unsigned WDC_CTRL_RUN_BIT = 1;

    // Counter layout and limits.
    localparam int unsigned WDC_COUNT_W = 24;
    localparam int unsigned WDC_BYTE_W = 8;
    localparam logic [23:0] WDC_COUNT_RST = {WDC_RST_UPPER, WDC_RST_MIDDLE, WDC_RST_LOWER};
    localparam logic [23:0] WDC_NO_REFRESH_LIMIT = 24'h000002;
    localparam logic [23:0] WDC_MIN_RELOAD = 24'h000004;
    localparam logic [23:0] WDC_TERMINAL = 24'h000001;
    localparam logic [23:0] WDC_ZERO = 24'h000000;

    // Timing: oscillator and system clock rates.
    localparam int unsigned WDC_OSC_FREQ_HZ = 10000;
    localparam int unsigned WDC_SYS_FREQ_HZ = 25000000;
    localparam int unsigned WDC_OSC_PERIOD_CYC = WDC_SYS_FREQ_HZ / WDC_OSC_FREQ_HZ;
    localparam int unsigned WDC_SYNC_STAGES = 2;

    typedef enum logic [0:0] {
        WDC_OFF = 1'b0,
        WDC_ON = 1'b1
    } wdc_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
    } wdc_reg_req_t;

endpackage
`default_nettype wire

// File: core/wdc_down_counter.sv
`default_nettype none
module wdc_down_counter #(
    parameter int unsigned WIDTH = 24,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic dec,
    // State
    output logic [WIDTH-1:0] count
);

    if (WIDTH < 2)
    begin : gBadWidth
        $error("wdc_down_counter needs at least two bits");
    end

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // A load always wins over a decrement in the same cycle.
    assign count_d = load ? loadValue : (dec ? count_q - WIDTH'(1) : count_q);
    assign count = count_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_q <= RESET_VAL;
        end
        else
        begin
            count_q <= count_d;
        end
    end

endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    wdc_pkg::wdc_reg_req_t regReq = '0;
    logic [7:0] regRdData;
    logic wdogOscClk = 1'b0;
    logic guardTimerRefreshOp = 1'b0;
    logic alwaysOnOptionBit = 1'b0;
    logic sysResetReq;
    logic timeoutIrq;
    logic wdogOn;
    logic [7:0] rdQ[$];
    logic [1:0] evQ[$];
    logic rdPend = 1'b0;
    logic [1:0] evExp;
    logic [23:0] rl;
    int fails = 0;
    int cmp_count = 0;

    wdc_top u_wdc_top (
        .clk_sys(clk_sys),
        .rst(rst),
        .regReq(regReq),
        .regRdData(regRdData),
        .wdogOscClk(wdogOscClk),
        .guardTimerRefreshOp(guardTimerRefreshOp),
        .alwaysOnOptionBit(alwaysOnOptionBit),
        .sysResetReq(sysResetReq),
        .timeoutIrq(timeoutIrq),
        .wdogOn(wdogOn)
    );

    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Results are compared at the falling edge, where registered outputs have settled.
    always @(negedge clk_sys)
    begin
        if (rdPend)
            check(rdQ.size() != 0 && regRdData === rdQ[0], "read data mismatch");
        else
            check(regRdData === 8'h00, "read data outside a read cycle");
        if (rdPend && rdQ.size() != 0)
            void'(rdQ.pop_front());
        rdPend = regReq.rd;
        if (sysResetReq !== 1'b0 || timeoutIrq !== 1'b0)
        begin
            evExp = (evQ.size() != 0) ? evQ[0] : 2'b00;
            check({sysResetReq, timeoutIrq} === evExp, "unexpected time-out pulse");
            if (evQ.size() != 0)
                void'(evQ.pop_front());
        end
    end

    // One register cycle; for a read the data argument is the expected answer.
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        if (!w)
            rdQ.push_back(d);
        regReq <= '{addr: a, wrData: w ? d : 8'h00, wr: w, rd: !w};
    endtask

    task automatic idle();
        @(posedge clk_sys);
        regReq.wr <= 1'b0;
        regReq.rd <= 1'b0;
    endtask

    task automatic rdCount(input logic [23:0] v);
        acc(1'b0, wdc_pkg::WDC_OFF_UPPER, v[23:16]);
        acc(1'b0, wdc_pkg::WDC_OFF_MIDDLE, v[15:8]);
        acc(1'b0, wdc_pkg::WDC_OFF_LOWER, v[7:0]);
        idle();
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic wrReload(input logic [23:0] v);
        acc(1'b1, wdc_pkg::WDC_OFF_UPPER, v[23:16]);
        acc(1'b1, wdc_pkg::WDC_OFF_MIDDLE, v[15:8]);
        acc(1'b1, wdc_pkg::WDC_OFF_LOWER, v[7:0]);
        idle();
    endtask

    // One oscillator period; ev notes the pulse expected from it, if any.
    task automatic tick(input logic [1:0] ev);
        if (ev != 2'b00)
            evQ.push_back(ev);
        @(posedge clk_sys);
        wdogOscClk <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wdogOscClk <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic refresh();
        @(posedge clk_sys);
        guardTimerRefreshOp <= 1'b1;
        @(posedge clk_sys);
        guardTimerRefreshOp <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_of_test();
        if (rdQ.size() != 0 || evQ.size() != 0)
        begin
            fails++;
            $display("[ERR] %0t expected results never appeared", $time);
        end
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        $display("[ERR] %0t run did not finish in time", $time);
        end_of_test();
    end

    initial
    begin
        void'($urandom(59));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(wdogOn === 1'b0, "watchdog on without enable");
        rdCount(24'h000400);
        acc(1'b0, wdc_pkg::WDC_OFF_CTRL, 8'h00);
        acc(1'b0, 12'hFFF, 8'h00);
        idle();
        tick(2'b00);
        rdCount(24'h000400);
        done("reset_and_off");
        rl = {8'($urandom_range(255, 1)), 16'($urandom)};
        wrReload(rl);
        rdCount(24'h000400);
        refresh();
        check(wdogOn === 1'b1, "refresh did not enable");
        rdCount(rl);
        tick(2'b00);
        rdCount(rl - 24'h000001);
        done("reload_and_refresh");
        wrReload(24'h000004);
        refresh();
        tick(2'b00);
        refresh();
        rdCount(24'h000004);
        tick(2'b00);
        tick(2'b00);
        refresh();
        rdCount(24'h000002);
        tick(2'b00);
        tick(2'b10);
        rdCount(24'h000000);
        done("reset_timeout");
        rst <= 1'b1;
        alwaysOnOptionBit <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check(wdogOn === 1'b1, "option bit did not enable");
        tick(2'b00);
        rdCount(24'h0003FF);
        wrReload(24'h000004);
        acc(1'b1, wdc_pkg::WDC_OFF_CTRL, 8'h01);
        acc(1'b0, wdc_pkg::WDC_OFF_CTRL, 8'h03);
        idle();
        refresh();
        repeat (3) tick(2'b00);
        tick(2'b01);
        rdCount(24'h000004);
        done("interrupt_timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
